// ===== hdl/sac_pkg.sv
`default_nettype none
package sac_pkg;
    // ************************************
    // Register map (byte addresses)
    // ************************************
    localparam int ADR_W = 8;
    localparam logic [7:0] OFF_CTL = 8'h00;
    localparam logic [7:0] OFF_RES = 8'h04;
    localparam logic [7:0] OFF_IST = 8'h08;
    localparam logic [7:0] OFF_IMK = 8'h0C;

    // ************************************
    // Status and control fields
    // ************************************
    localparam int CC_BIT = 7;
    localparam int RC_BIT = 6;
    localparam int ON_BIT = 5;
    localparam int CH_LSB = 0;
    localparam int CH_W = 3;
    localparam logic [2:0] CH_RESET = 3'h0;
    localparam logic [2:0] CH_EXT0 = 3'h0;
    localparam logic [2:0] CH_EXT1 = 3'h1;
    localparam int PA_EXT0_BIT = 4;
    localparam int PA_EXT1_BIT = 5;

    // ************************************
    // Interrupt status bits
    // ************************************
    localparam int IRQ_W = 2;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ABORT = 1;

    // ************************************
    // Timing
    // ************************************
    localparam int RES_W = 8;
    localparam int STEP_W = 5;
    localparam logic [4:0] LAST_STEP = 5'h1F;
    localparam int RESTART_CYCLES = 256;
    localparam int SETTLE_W = 16;
endpackage
`default_nettype wire

// ===== hdl/sac_sar_core.sv
`timescale 1ns/1ns
`default_nettype none
module sac_sar_core
(
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic start,
    input wire logic abort,
    input wire logic comp_in,
    output logic [sac_pkg::RES_W-1:0] dac_code,
    output logic sample_hold,
    output logic done,
    output logic [sac_pkg::RES_W-1:0] result
);
    typedef struct packed {
        logic busy;
        logic [sac_pkg::STEP_W-1:0] step;
        logic [sac_pkg::RES_W-1:0] dac;
        logic [sac_pkg::RES_W-1:0] sar;
        logic [sac_pkg::RES_W-1:0] result;
        logic sample;
        logic done;
    } sac_core_t;

    sac_core_t st_reg;
    sac_core_t st_next;

    function automatic logic [sac_pkg::RES_W-1:0] trial_mask(input logic [4:0] step);
        trial_mask = 8'h80 >> step[4:2];
    endfunction

    always_comb
    begin
        st_next = st_reg;
        st_next.sample = 1'b0;
        st_next.done = 1'b0;
        if (abort)
        begin
            st_next.busy = 1'b0;
            st_next.step = '0;
            st_next.dac = '0;
            st_next.sar = '0;
        end
        else if (start)
        begin
            st_next.busy = 1'b1;
            st_next.step = '0;
            st_next.dac = '0;
            st_next.sar = '0;
        end
        else if (st_reg.busy && tick)
        begin
            // Sample once, then hold it for all eight trials
            if (st_reg.step == '0)
            begin
                st_next.sample = 1'b1;
            end
            if (st_reg.step[1:0] == 2'b01)
            begin
                st_next.dac = st_reg.sar | trial_mask(st_reg.step);
            end
            // Comparator high keeps the trial bit; at full scale all bits stay
            if (st_reg.step[1:0] == 2'b11 && comp_in)
            begin
                st_next.sar = st_reg.dac;
            end
            if (st_reg.step == sac_pkg::LAST_STEP)
            begin
                st_next.result = comp_in ? st_reg.dac : st_reg.sar;
                st_next.done = 1'b1;
                st_next.sar = '0;
                st_next.step = '0;
            end
            else
            begin
                st_next.step = st_reg.step + 5'h01;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign dac_code = st_reg.dac;
    assign sample_hold = st_reg.sample;
    assign done = st_reg.done;
    assign result = st_reg.result;
endmodule // sac_sar_core
`default_nettype wire

// ===== hdl/sac_adc_top.sv
// Summary of operation
// - The converter builds an 8-bit code by successive approximation against a trial level.
// - Full-scale input gives all ones, ground gives all zeros, overrange saturates silently.
// - One conversion takes exactly 32 converter clock ticks on the bus clock.
// - Below 1 MHz bus clock software selects the RC oscillator to clock the converter.
// - With the RC oscillator, completion is signalled by the complete flag that software polls.
// - The input is sampled once at the start of each conversion and then held.
// - A multiplexer routes one of two external inputs, shared with port A bits 4 and 5.
// - The converter keeps running normally during wait mode.
// - Stop mode halts the converter and aborts any conversion in progress.
// - After stop a built-in restart delay lets the converter settle before converting.
// - The complete flag sets on a result and clears on channel write, result read or power off.
// - Conversions repeat every 32 ticks, overwriting the result, until control is rewritten.
// - Channel codes 0 and 1 pick external inputs, 4 to 6 references, others are undefined.
// - With the converter on and a shared channel selected, the pin reads zero or its latch.
//
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module sac_adc_top
#(
    parameter int RESTART_CYCLES = sac_pkg::RESTART_CYCLES
)
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [sac_pkg::ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic WB_ACK_O,
    output logic [31:0] WB_DAT_O,
    output logic IRQ,
    input wire logic RC_OSC_CLK,
    input wire logic STOP_MODE,
    input wire logic COMP_IN,
    output logic [7:0] DAC_CODE,
    output logic SAMPLE_HOLD,
    output logic [2:0] MUX_SEL,
    output logic ANALOG_EN,
    output logic RC_OSC_EN,
    input wire logic [7:0] PORTA_PIN,
    input wire logic [7:0] PORTA_DDR,
    input wire logic [7:0] PORTA_LATCH,
    output logic [7:0] PORTA_READ
);
    // ************************************
    // State
    // ************************************
    typedef struct packed {
        logic rc_sel;
        logic power_on;
        logic [sac_pkg::CH_W-1:0] channel;
        logic cc;
        logic [sac_pkg::IRQ_W-1:0] ist;
        logic [sac_pkg::IRQ_W-1:0] imk;
        logic irq;
        logic ack;
        logic [31:0] dat;
        logic rc_s1;
        logic rc_s2;
        logic rc_prev;
        logic start;
        logic pend;
        logic stopped;
        logic [sac_pkg::SETTLE_W-1:0] settle;
        logic [2:0] mux;
        logic aen;
        logic rcen;
        logic [7:0] porta;
    } sac_top_t;

    sac_top_t st_reg;
    sac_top_t st_next;

    logic core_tick;
    logic core_abort;
    logic core_done;
    logic [7:0] core_result;
    logic wb_req;
    logic wb_commit;
    logic [7:0] ctl_view;
    logic ctl_write;

    function automatic logic is_shared(input logic [2:0] ch, input logic [2:0] code);
        is_shared = (ch == code);
    endfunction

    // RC clock edge: first flop feeds only the second
    assign core_tick = st_reg.rc_sel ? (st_reg.rc_s2 & ~st_reg.rc_prev) : 1'b1;
    assign core_abort = ~st_reg.power_on | STOP_MODE | st_reg.stopped;
    assign wb_req = WB_CYC_I & WB_STB_I;
    assign wb_commit = wb_req & st_reg.ack;
    assign ctl_write = wb_commit & WB_WE_I & WB_SEL_I[0] & (WB_ADR_I == sac_pkg::OFF_CTL);
    assign ctl_view = {st_reg.cc, st_reg.rc_sel, st_reg.power_on, 2'b00, st_reg.channel};

    sac_sar_core u_core
    (
        .clk(REF_CLK),
        .rst(RST),
        .tick(core_tick),
        .start(st_reg.start),
        .abort(core_abort),
        .comp_in(COMP_IN),
        .dac_code(DAC_CODE),
        .sample_hold(SAMPLE_HOLD),
        .done(core_done),
        .result(core_result)
    );

    always_comb
    begin
        st_next = st_reg;
        st_next.start = 1'b0;
        // ************************************
        // Synchronizer
        // ************************************
        st_next.rc_s1 = RC_OSC_CLK;
        st_next.rc_s2 = st_reg.rc_s1;
        st_next.rc_prev = st_reg.rc_s2;

        // ************************************
        // Bus slave
        // ************************************
        // Ack one cycle after request; write lands on the edge that sees ack
        st_next.ack = wb_req & ~st_reg.ack;
        if (wb_req && !st_reg.ack)
        begin
            unique case (WB_ADR_I)
                sac_pkg::OFF_CTL: st_next.dat = {24'h00_0000, ctl_view};
                sac_pkg::OFF_RES: st_next.dat = {24'h00_0000, core_result};
                sac_pkg::OFF_IST: st_next.dat = {30'h0000_0000, st_reg.ist};
                sac_pkg::OFF_IMK: st_next.dat = {30'h0000_0000, st_reg.imk};
                default: st_next.dat = 32'h0000_0000;
            endcase
        end
        if (wb_commit && !WB_WE_I && WB_ADR_I == sac_pkg::OFF_RES)
        begin
            st_next.cc = 1'b0;
        end
        if (wb_commit && WB_WE_I && WB_SEL_I[0])
        begin
            unique case (WB_ADR_I)
                sac_pkg::OFF_CTL:
                begin
                    st_next.rc_sel = WB_DAT_I[sac_pkg::RC_BIT];
                    st_next.power_on = WB_DAT_I[sac_pkg::ON_BIT];
                    st_next.channel = WB_DAT_I[sac_pkg::CH_LSB +: sac_pkg::CH_W];
                    st_next.cc = 1'b0;
                    // A control write with the power bit set restarts continuous conversion
                    st_next.pend = WB_DAT_I[sac_pkg::ON_BIT];
                end
                sac_pkg::OFF_IST: st_next.ist = st_reg.ist & ~WB_DAT_I[sac_pkg::IRQ_W-1:0];
                sac_pkg::OFF_IMK: st_next.imk = WB_DAT_I[sac_pkg::IRQ_W-1:0];
                default: st_next.imk = st_reg.imk;
            endcase
        end
        if (!st_next.power_on)
        begin
            st_next.cc = 1'b0;
            st_next.pend = 1'b0;
        end

        // ************************************
        // Stop and restart delay
        // ************************************
        // Wait mode has no input here: the converter simply keeps going
        if (STOP_MODE)
        begin
            // Powered means converting: a power-on write starts a run, except one made in the last cycle of stop mode while power was off
            if (!st_reg.stopped && st_reg.power_on)
            begin
                st_next.ist[sac_pkg::IRQ_ABORT] = 1'b1;
            end
            st_next.stopped = 1'b1;
            st_next.settle = 16'(RESTART_CYCLES);
            st_next.pend = st_reg.power_on;
        end
        else if (st_reg.stopped)
        begin
            if (st_reg.settle == '0)
            begin
                st_next.stopped = 1'b0;
            end
            else
            begin
                st_next.settle = st_reg.settle - 16'h0001;
            end
        end
        else if (st_next.pend)
        begin
            st_next.start = 1'b1;
            st_next.pend = 1'b0;
        end

        // ************************************
        // Completion; set wins over the result-read clear
        // ************************************
        // Done of a run cut short by a control write belongs to the old channel
        if (core_done && !core_abort && !st_reg.start && !ctl_write)
        begin
            st_next.cc = 1'b1;
            st_next.ist[sac_pkg::IRQ_DONE] = 1'b1;
        end
        st_next.irq = |(st_next.ist & st_next.imk);

        // ************************************
        // Analog controls and port A view
        // ************************************
        st_next.mux = st_next.channel;
        st_next.aen = st_next.power_on & ~STOP_MODE;
        // Oscillator left to software; only stop forces it off
        st_next.rcen = st_next.rc_sel & ~STOP_MODE;
        st_next.porta = PORTA_PIN;
        for (int i = 0; i < 8; i++)
        begin
            if (PORTA_DDR[i])
            begin
                st_next.porta[i] = PORTA_LATCH[i];
            end
        end
        if (st_next.power_on && !PORTA_DDR[sac_pkg::PA_EXT0_BIT]
            && is_shared(st_next.channel, sac_pkg::CH_EXT0))
        begin
            st_next.porta[sac_pkg::PA_EXT0_BIT] = 1'b0;
        end
        if (st_next.power_on && !PORTA_DDR[sac_pkg::PA_EXT1_BIT]
            && is_shared(st_next.channel, sac_pkg::CH_EXT1))
        begin
            st_next.porta[sac_pkg::PA_EXT1_BIT] = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign WB_ACK_O = st_reg.ack;
    assign WB_DAT_O = st_reg.dat;
    assign IRQ = st_reg.irq;
    assign MUX_SEL = st_reg.mux;
    assign ANALOG_EN = st_reg.aen;
    assign RC_OSC_EN = st_reg.rcen;
    assign PORTA_READ = st_reg.porta;
endmodule // sac_adc_top
`default_nettype wire

// ===== dv/sac_adc_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module sac_adc_asserts
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic WB_ACK_O,
    input wire logic STOP_MODE,
    input wire logic [7:0] DAC_CODE,
    input wire logic SAMPLE_HOLD,
    input wire logic [2:0] MUX_SEL,
    input wire logic ANALOG_EN,
    input wire logic RC_OSC_EN,
    input wire logic [7:0] PORTA_DDR,
    input wire logic [7:0] PORTA_LATCH,
    input wire logic [7:0] PORTA_READ
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // Cycles since last sample; 63 means any write or stop broke the run
    logic [5:0] gap_reg;
    always_ff @(posedge REF_CLK)
    begin
        if (RST || STOP_MODE || (WB_CYC_I && WB_WE_I))
            gap_reg <= 6'h3F;
        else if (SAMPLE_HOLD)
            gap_reg <= 6'h00;
        else if (gap_reg != 6'h3F)
            gap_reg <= gap_reg + 6'h01;
    end
    // High in the cycle after a write took effect; a restart may follow it
    logic commit_reg;
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            commit_reg <= 1'b0;
        else
            commit_reg <= WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O;
    end
    a_ack_answer: assert property
        (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("no ack");
    a_sample_once: assert property (
        SAMPLE_HOLD |=> (!SAMPLE_HOLD || gap_reg == 6'h3F) [*8]) else $error("second sample");
    a_msb_first: assert property (
        SAMPLE_HOLD && !RC_OSC_EN && !STOP_MODE && !commit_reg |=> DAC_CODE == 8'h80)
        else $error("first trial");
    a_repeat_period: assert property (
        SAMPLE_HOLD && !RC_OSC_EN && gap_reg != 6'h3F |-> gap_reg == 6'h1F)
        else $error("period not 32");
    a_stop_halts: assert property (
        STOP_MODE |=> !ANALOG_EN && !RC_OSC_EN && !SAMPLE_HOLD) else $error("stop ignored");
    a_stop_settle: assert property (
        $fell(STOP_MODE) |-> !SAMPLE_HOLD [*5]) else $error("no settle delay");
    a_port_zero: assert property (
        (ANALOG_EN && MUX_SEL == 3'h0 && !PORTA_DDR[4]) [*2] |-> !PORTA_READ[4])
        else $error("shared pin not zero");
    a_port_latch: assert property (
        (ANALOG_EN && MUX_SEL == 3'h1 && PORTA_DDR[5]) [*2]
        |-> PORTA_READ[5] == $past(PORTA_LATCH[5])) else $error("shared pin not latch");
endmodule // sac_adc_asserts
bind sac_adc_top sac_adc_asserts chk_u (.*);
`default_nettype wire

// ===== dv/sac_analog_model.sv
`timescale 1ns/1ns
`default_nettype none
module sac_analog_model
(
    input wire logic clk,
    input wire logic sample_hold,
    input wire logic analog_en,
    input wire logic [2:0] mux_sel,
    input wire logic [7:0] dac_code,
    input wire logic [7:0] ain0,
    input wire logic [7:0] ain1,
    output logic comp
);
    logic [7:0] held;
    logic [7:0] chan;
    logic flip = 1'h0;
    always_comb
    begin
        case (mux_sel)
            3'h0: chan = ain0;
            3'h1: chan = ain1;
            3'h4: chan = 8'hFF;
            3'h5: chan = 8'h80;
            3'h6: chan = 8'h00;
            default: chan = {4{flip, ~flip}};
        endcase
    end
    always_ff @(posedge clk)
    begin
        flip <= ~flip;
        if (sample_hold)
            held <= chan;
    end
    // Unpowered comparator wanders rather than settling
    assign comp = analog_en ? (held >= dac_code) : flip;
endmodule // sac_analog_model
`default_nettype wire

// ===== dv/test_sar_adc_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_sar_adc_control;
    logic clk = 1'h0, rst = 1'h1, cyc = 1'h0, we = 1'h0, stop = 1'h0;
    logic rc = 1'h0, rc_run = 1'h0, rcb, ack, irq, comp, sh, aen, rcen;
    logic [7:0] adr = 8'h00, pin = 8'h00, ddr = 8'h00, lat = 8'h00;
    logic [7:0] ain0 = 8'h00, ain1 = 8'h00, dac, prd;
    logic [31:0] dat = 32'h0000_0000, rdat, q, seed = 32'h0000_0053;
    logic [2:0] msel, ch;
    logic [2:0] chans [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
    int miscompares = 0, total_checks = 0, n;
    always #5 clk = ~clk;
    // RC clock is unrelated to the bus clock and stands still when unused
    always #31 rc = rc_run & ~rc;
    sac_adc_top #(.RESTART_CYCLES(4)) dut_u
    (
        .REF_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_ACK_O(ack), .WB_DAT_O(rdat),
        .IRQ(irq), .RC_OSC_CLK(rc), .STOP_MODE(stop), .COMP_IN(comp), .DAC_CODE(dac),
        .SAMPLE_HOLD(sh), .MUX_SEL(msel), .ANALOG_EN(aen), .RC_OSC_EN(rcen),
        .PORTA_PIN(pin), .PORTA_DDR(ddr), .PORTA_LATCH(lat), .PORTA_READ(prd)
    );
    sac_analog_model model_u
    (
        .clk(clk), .sample_hold(sh), .analog_en(aen), .mux_sel(msel), .dac_code(dac),
        .ain0(ain0), .ain1(ain1), .comp(comp)
    );
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [7:0] expv(input logic [2:0] c);
        case (c)
            3'h0: return ain0;
            3'h1: return ain1;
            3'h4: return 8'hFF;
            3'h5: return 8'h80;
            default: return 8'h00;
        endcase
    endfunction
    task automatic end_sim();
        if (miscompares == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic fail();
        miscompares++;
        end_sim();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'h1;
        we <= w;
        adr <= a;
        dat <= d;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (ack !== 1'h1 && k < 20);
        q = rdat;
        cyc <= 1'h0;
        @(posedge clk);
        if (k >= 20)
            fail();
    endtask
    task automatic wait_cc();
        int k;
        k = 0;
        do
        begin
            wb(1'h0, sac_pkg::OFF_CTL, 32'h0000_0000);
            k++;
        end
        while (q[7] !== 1'h1 && k < 150);
        if (k >= 150)
            fail();
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        wb(1'h0, sac_pkg::OFF_CTL, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        wb(1'h0, 8'h10, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        wb(1'h1, sac_pkg::OFF_IMK, 32'h0000_0002);
        for (int i = 0; i < 10; i++)
        begin
            seed = xs(seed);
            ch = chans[i % 5];
            rcb = (i > 5);
            ain0 <= seed[7:0];
            ain1 <= seed[15:8];
            rc_run <= rcb;
            wb(1'h1, sac_pkg::OFF_CTL, {24'h00_0000, 1'h0, rcb, 1'h1, 2'h0, ch});
            repeat (2) @(posedge clk);
            chk(32'(rcen), 32'(rcb));
            wait_cc();
            chk(32'(irq), 32'h0000_0000);
            wb(1'h0, sac_pkg::OFF_RES, 32'h0000_0000);
            chk(q, {24'h00_0000, expv(ch)});
            wb(1'h0, sac_pkg::OFF_CTL, 32'h0000_0000);
            chk(32'(q[7]), 32'h0000_0000);
        end
        wb(1'h1, sac_pkg::OFF_CTL, 32'h0000_0021);
        rc_run <= 1'h0;
        wait_cc();
        ain1 <= ~ain1;
        for (n = 0; n < 40 && sh !== 1'h1; n++)
            @(posedge clk);
        @(posedge clk);
        for (n = 1; n < 40 && sh !== 1'h1; n++)
            @(posedge clk);
        chk(32'(n), 32'h0000_0020);
        repeat (70) @(posedge clk);
        wb(1'h0, sac_pkg::OFF_RES, 32'h0000_0000);
        chk(q, {24'h00_0000, ain1});
        ddr <= 8'h20;
        wb(1'h1, sac_pkg::OFF_IST, 32'h0000_0003);
        wb(1'h1, sac_pkg::OFF_CTL, 32'h0000_0021);
        repeat (12) @(posedge clk);
        stop <= 1'h1;
        repeat (3) @(posedge clk);
        chk(32'(aen), 32'h0000_0000);
        wb(1'h0, sac_pkg::OFF_IST, 32'h0000_0000);
        chk(32'(q[1]), 32'h0000_0001);
        chk(32'(irq), 32'h0000_0001);
        stop <= 1'h0;
        wait_cc();
        wb(1'h0, sac_pkg::OFF_RES, 32'h0000_0000);
        chk(q, {24'h00_0000, ain1});
        wb(1'h1, sac_pkg::OFF_IST, 32'h0000_0002);
        @(posedge clk);
        chk(32'(irq), 32'h0000_0000);
        seed = xs(seed);
        pin <= seed[7:0];
        lat <= seed[15:8];
        ddr <= 8'h00;
        wb(1'h1, sac_pkg::OFF_CTL, 32'h0000_0020);
        repeat (2) @(posedge clk);
        chk(32'(prd), 32'(pin & 8'hEF));
        ddr <= 8'h10;
        repeat (3) @(posedge clk);
        chk(32'(prd), 32'({pin[7:5], lat[4], pin[3:0]}));
        wait_cc();
        wb(1'h1, sac_pkg::OFF_CTL, 32'h0000_0000);
        wb(1'h0, sac_pkg::OFF_CTL, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        ddr <= 8'h00;
        repeat (3) @(posedge clk);
        chk(32'(prd), 32'(pin));
        end_sim();
    end
endmodule // test_sar_adc_control
`default_nettype wire
